// >>> logic/ehp_host_port.sv
`timescale 1ns/100ps
`include "ehp_regs.svh"

//------------------------------------------------------------
// small fifo
//------------------------------------------------------------
module ehp_fifo #(
  parameter int W = 9,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);
  // count is one bit wider than the pointers, so full and empty differ
  logic [W-1:0] mem [D];
  logic [AW-1:0] wPtr_r, wPtr_nxt, rPtr_r, rPtr_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign inReady  = (cnt_r != D[AW:0]);
  assign outValid = (cnt_r != '0);
  assign outData  = mem[rPtr_r];

  always_comb begin
    push     = inValid & inReady;
    pop      = outValid & outReady;
    wPtr_nxt = push ? AW'(wPtr_r + 1'b1) : wPtr_r;
    rPtr_nxt = pop ? AW'(rPtr_r + 1'b1) : rPtr_r;
    cnt_nxt  = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wPtr_r <= '0;
      rPtr_r <= '0;
      cnt_r  <= '0;
    end else begin
      wPtr_r <= wPtr_nxt;
      rPtr_r <= rPtr_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  // storage has no reset; the count and the pointers say what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wPtr_r] <= inData;
    end
  end
endmodule : ehp_fifo

//------------------------------------------------------------
// host port top
//------------------------------------------------------------
module ehp_host_port
  import ehp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       serialClk,
  input  wire logic       reset_n_pin,
  input  wire logic       iface_sel_lo,
  input  wire logic       iface_sel_hi,
  input  wire logic       csN,
  input  wire logic       rwWrN,
  input  wire logic       enRdN,
  input  wire logic       dcSel,
  input  wire logic [7:0] busIn,
  output logic      [7:0] busOut,
  output logic            busOe,
  input  wire logic [7:0] statusByte,
  input  wire logic       coreBusy,
  output logic            memRdReq,
  input  wire logic [7:0] memRdData,
  input  wire logic       memRdValid,
  output logic            wrValid,
  output logic            wrIsData,
  output logic      [7:0] wrByte,
  input  wire logic       wrReady,
  output logic            busy,
  output logic            overflow,
  output logic      [1:0] ifaceMode
);
  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  logic [14:0] pinRaw, s1_r, s2_r, s3_r;
  assign pinRaw = {reset_n_pin, iface_sel_hi, iface_sel_lo, csN, rwWrN, enRdN, dcSel, busIn};

  // the reset pin bit resets low, so a system reset holds the port for
  // two more cycles while real pin levels fill the chain
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r <= `EHP_SYNC_RST;
      s2_r <= `EHP_SYNC_RST;
      s3_r <= `EHP_SYNC_RST;
    end else begin
      s1_r <= pinRaw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic portRst;
  logic csNow, csWas, wrNow, wrWas, rdNow, rdWas, dcNow;
  logic [7:0] busNow;
  assign portRst = sys_rst | ~s2_r[`EHP_PIN_RSTN]; // RQ18
  assign csNow   = s2_r[`EHP_PIN_CS];
  assign csWas   = s3_r[`EHP_PIN_CS];
  assign wrNow   = s2_r[`EHP_PIN_WR];
  assign wrWas   = s3_r[`EHP_PIN_WR];
  assign rdNow   = s2_r[`EHP_PIN_RD];
  assign rdWas   = s3_r[`EHP_PIN_RD];
  assign dcNow   = s3_r[`EHP_PIN_DC];
  assign busNow  = s3_r[7:0];

  //------------------------------------------------------------
  // strap capture
  //------------------------------------------------------------
  // capture lasts one cycle past port reset: right after a system
  // reset the synchroniser still shows its own reset value
  logic      linkRst_r;
  ehp_mode_e mode_r, mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    if (portRst || linkRst_r) begin
      mode_nxt = decodeMode(s2_r[`EHP_PIN_SELHI], s2_r[`EHP_PIN_SELLO]); // RQ1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_r <= EHP_SPI4;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  //------------------------------------------------------------
  // serial link domain
  //------------------------------------------------------------
  // reset held toward the link; async since its clock may stand still
  always_ff @(posedge ref_clk) begin
    linkRst_r <= portRst;
  end

  logic       frameRst;
  logic [3:0] bitCnt_r, bitCnt_nxt, frameLen;
  logic [8:0] sh_r, sh_nxt;
  logic [7:0] serByte_r, serByte_nxt;
  logic       serDc_r, serDc_nxt, serTog_r, serTog_nxt, frameDone;

  assign frameRst = csN | linkRst_r; // RQ19

  always_comb begin
    frameLen    = iface_sel_hi ? `EHP_SPI3_BITS : `EHP_SPI4_BITS; // RQ14
    sh_nxt      = {sh_r[7:0], busIn[1]}; // RQ9 RQ11
    frameDone   = (4'(bitCnt_r + 1'b1) == frameLen);
    bitCnt_nxt  = frameDone ? `EHP_CNT_RST : 4'(bitCnt_r + 1'b1);
    serByte_nxt = serByte_r;
    serDc_nxt   = serDc_r;
    serTog_nxt  = serTog_r;
    if (frameDone) begin
      serByte_nxt = sh_nxt[7:0];
      serDc_nxt   = iface_sel_hi ? sh_nxt[8] : dcSel; // RQ14 RQ15
      serTog_nxt  = ~serTog_r; // RQ12
    end
  end

  // serialClk is the bus bit 0 wire
  always_ff @(posedge serialClk or posedge frameRst) begin // RQ10
    if (frameRst) begin
      bitCnt_r <= `EHP_CNT_RST;
      sh_r     <= `EHP_SH_RST;
    end else begin
      bitCnt_r <= bitCnt_nxt;
      sh_r     <= sh_nxt;
    end
  end

  // the toggle ignores chip select so a frame that closes right as
  // select rises is still handed over
  always_ff @(posedge serialClk or posedge linkRst_r) begin
    if (linkRst_r) begin
      serTog_r <= 1'b0;
    end else begin
      serTog_r <= serTog_nxt;
    end
  end

  always_ff @(posedge serialClk or posedge linkRst_r) begin
    if (linkRst_r) begin
      serByte_r <= `EHP_BYTE_RST;
      serDc_r   <= 1'b0;
    end else begin
      serByte_r <= serByte_nxt;
      serDc_r   <= serDc_nxt;
    end
  end

  //------------------------------------------------------------
  // serial toggle crossing
  //------------------------------------------------------------
  logic tg1_r, tg2_r, tg3_r, serEvent;
  always_ff @(posedge ref_clk) begin
    if (portRst) begin
      tg1_r <= 1'b0;
      tg2_r <= 1'b0;
      tg3_r <= 1'b0;
    end else begin
      tg1_r <= serTog_r;
      tg2_r <= tg1_r;
      tg3_r <= tg2_r;
    end
  end
  // the mode gate keeps parallel traffic on bus bit 0 from posing as frames
  assign serEvent = (tg2_r ^ tg3_r) & ((mode_r == EHP_SPI4) | (mode_r == EHP_SPI3));

  //------------------------------------------------------------
  // parallel decode
  //------------------------------------------------------------
  logic parWrite, parRead, readPhase;
  // edges compare stage two with stage three; select and data come from
  // stage three, which the host holds steady around the edge

  always_comb begin
    parWrite  = 1'b0;
    parRead   = 1'b0;
    readPhase = 1'b0;
    unique case (mode_r)
      EHP_ENABLE: begin
        // enable falls while selected
        if (!csNow && rose(rdWas, rdNow)) begin // RQ4
          parWrite = ~wrNow; // RQ2
          parRead  = wrNow;
        end
        readPhase = ~csNow & wrNow & rdNow;
      end
      EHP_STROBE: begin
        if (!csNow && rose(wrNow, wrWas) && rdNow) begin // RQ7
          parWrite = 1'b1;
        end
        if (!csNow && rose(rdNow, rdWas) && wrNow) begin // RQ6
          parRead = 1'b1;
        end
        if (rose(csNow, csWas)) begin // RQ8
          parWrite = ~wrNow & rdNow;
          parRead  = ~rdNow & wrNow;
        end
        readPhase = ~csNow & ~rdNow & wrNow;
      end
      default: begin
        readPhase = 1'b0; // RQ13
      end
    endcase
  end

  //------------------------------------------------------------
  // write path into fifo
  //------------------------------------------------------------
  logic       pushValid, fifoInReady, fifoOutValid, fifoPop;
  logic [8:0] pushData, fifoOut;

  always_comb begin
    pushValid = parWrite | serEvent;
    pushData  = serEvent ? {serDc_r, serByte_r} : {dcNow, busNow}; // RQ3
  end

  ehp_fifo #(
    .W (`EHP_FIFO_W),
    .D (`EHP_FIFO_D)
  ) u_fifo (
    .clk      (ref_clk),
    .rst      (portRst),
    .inValid  (pushValid),
    .inData   (pushData),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOut),
    .outReady (fifoPop)
  );

  // output stage so the core sees flop-driven strobes
  logic       wrValid_r, wrValid_nxt, wrIsData_r, wrIsData_nxt;
  logic [7:0] wrByte_r, wrByte_nxt;
  logic       ovf_r, ovf_nxt, busy_r, busy_nxt;

  always_comb begin
    fifoPop      = ~wrValid_r | wrReady;
    wrValid_nxt  = wrValid_r;
    wrIsData_nxt = wrIsData_r;
    wrByte_nxt   = wrByte_r;
    if (fifoPop) begin
      wrValid_nxt  = fifoOutValid;
      wrIsData_nxt = fifoOut[8]; // RQ12 RQ16
      wrByte_nxt   = fifoOut[7:0];
    end
    // a write into a full fifo is lost, flag it
    ovf_nxt  = ovf_r | (pushValid & ~fifoInReady);
    // busy follows a full fifo one cycle late: keep writes spaced
    busy_nxt = coreBusy | ~fifoInReady; // RQ17
  end

  always_ff @(posedge ref_clk) begin
    if (portRst) begin
      wrValid_r  <= 1'b0;
      wrIsData_r <= 1'b0;
      wrByte_r   <= `EHP_BYTE_RST;
      ovf_r      <= 1'b0;
      busy_r     <= 1'b1;
    end else begin
      wrValid_r  <= wrValid_nxt;
      wrIsData_r <= wrIsData_nxt;
      wrByte_r   <= wrByte_nxt;
      ovf_r      <= ovf_nxt;
      busy_r     <= busy_nxt;
    end
  end

  //------------------------------------------------------------
  // read path
  //------------------------------------------------------------
  // memory reads are pipelined: each data read returns the byte
  // fetched by the one before, hence the host's dummy read
  logic [7:0] rdLatch_r, rdLatch_nxt, busOut_r, busOut_nxt;
  logic       busOe_r, busOe_nxt, rdReq_r, rdReq_nxt;

  always_comb begin
    rdReq_nxt   = parRead & dcNow; // RQ5
    rdLatch_nxt = memRdValid ? memRdData : rdLatch_r;
    // the bus turns on a few cycles into the read phase; sample late
    busOe_nxt   = readPhase;
    busOut_nxt  = dcNow ? rdLatch_r : statusByte; // RQ3
  end

  always_ff @(posedge ref_clk) begin
    if (portRst) begin
      rdReq_r   <= 1'b0;
      rdLatch_r <= `EHP_BYTE_RST;
      busOe_r   <= 1'b0;
      busOut_r  <= `EHP_BYTE_RST;
    end else begin
      rdReq_r   <= rdReq_nxt;
      rdLatch_r <= rdLatch_nxt;
      busOe_r   <= busOe_nxt;
      busOut_r  <= busOut_nxt;
    end
  end

  assign busOut    = busOut_r;
  assign busOe     = busOe_r;
  assign memRdReq  = rdReq_r;
  assign wrValid   = wrValid_r;
  assign wrIsData  = wrIsData_r;
  assign wrByte    = wrByte_r;
  assign busy      = busy_r;
  assign overflow  = ovf_r;
  assign ifaceMode = mode_r;
endmodule : ehp_host_port

// >>> logic/ehp_regs.svh
`ifndef EHP_REGS_SVH
`define EHP_REGS_SVH
//------------------------------------------------------------
// Operation
//------------------------------------------------------------
// Operation
// RQ1: two straps pick one of four host interfaces
// RQ2: enable mode: direction low writes, high reads
// RQ3: select low command/status, high display data
// RQ4: enable mode latches on falling enable edge
// RQ5: host discards one dummy read first
// RQ6: strobe mode: read ends on read rising edge
// RQ7: strobe mode: write latched on write rising edge
// RQ8: static strobes, chip select rising edge latches
// RQ9: bus bit 0 clocks, bit 1 carries serial data
// RQ10: serial bits sampled on rising clock, select low
// RQ11: four-wire: eight bits, most significant first
// RQ12: completed byte goes to memory or command
// RQ13: serial modes are write only
// RQ14: three-wire: nine bits, leading bit picks target
// RQ15: three-wire ignores the select pin
// RQ16: two one-bit planes, 240 by 320 each
// RQ17: host sends nothing while busy is high
// RQ18: low reset pin resets the host port
// RQ19: chip select high drops partial serial frame
//------------------------------------------------------------
`define EHP_FIFO_W      9
`define EHP_FIFO_D      4
`define EHP_SPI4_BITS   4'h8
`define EHP_SPI3_BITS   4'h9
`define EHP_PLANE_W     240
`define EHP_PLANE_H     320
`define EHP_PLANES      2
`define EHP_BYTE_RST    8'h00
`define EHP_CNT_RST     4'h0
`define EHP_SH_RST      9'h000
`define EHP_SYNC_RST    15'h3FFF
`define EHP_PIN_RSTN    14
`define EHP_PIN_SELHI   13
`define EHP_PIN_SELLO   12
`define EHP_PIN_CS      11
`define EHP_PIN_WR      10
`define EHP_PIN_RD      9
`define EHP_PIN_DC      8
`endif

// >>> logic/ehp_pkg.sv
package ehp_pkg;
  typedef enum logic [1:0] {
    EHP_SPI4,
    EHP_STROBE,
    EHP_SPI3,
    EHP_ENABLE
  } ehp_mode_e;

  // straps: {high, low}
  function automatic ehp_mode_e decodeMode(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00:   decodeMode = EHP_SPI4;
      2'b01:   decodeMode = EHP_STROBE;
      2'b10:   decodeMode = EHP_SPI3;
      default: decodeMode = EHP_ENABLE;
    endcase
  endfunction : decodeMode

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction : rose
endpackage : ehp_pkg

// >>> sim/ehp_host_port_sva.sv
`timescale 1ns/100ps
//----------------------------
// port checker
//----------------------------
module ehp_host_port_sva (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       reset_n_pin,
  input wire logic       iface_sel_lo,
  input wire logic       iface_sel_hi,
  input wire logic       csN,
  input wire logic       rwWrN,
  input wire logic       enRdN,
  input wire logic       dcSel,
  input wire logic       busOe,
  input wire logic       coreBusy,
  input wire logic       memRdReq,
  input wire logic       wrValid,
  input wire logic       wrIsData,
  input wire logic [7:0] wrByte,
  input wire logic       wrReady,
  input wire logic       busy,
  input wire logic [1:0] ifaceMode
);
  wire logic [1:0] strap = {iface_sel_hi, iface_sel_lo};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // pins pass two sync flops, so latch events show up a few cycles late
  sequence enWr_s; ifaceMode == 2'h3 && !csN && !rwWrN && $fell(enRdN); endsequence
  sequence stWr_s; ifaceMode == 2'h1 && !csN && enRdN && $rose(rwWrN); endsequence
  sequence csWr_s; ifaceMode == 2'h1 && !rwWrN && enRdN && $rose(csN); endsequence
  sequence dRd_s; ifaceMode == 2'h1 && !csN && rwWrN && dcSel && $rose(enRdN); endsequence
  sequence pinRst_s; !reset_n_pin [*3]; endsequence
  mode_decode_a: assert property (pinRst_s |=> ifaceMode == strap)
    else $error("mode differs from straps");
  mode_boot_a: assert property ($past(sys_rst) |-> ##3 ifaceMode == strap)
    else $error("mode not caught after system reset");
  pin_reset_a: assert property (pinRst_s |=> busy && !(wrValid || busOe || memRdReq))
    else $error("outputs not idle in pin reset");
  serial_no_read_a: assert property (!ifaceMode[0] |-> !busOe)
    else $error("bus driven in serial mode");
  reset_idle_a: assert property ($past(sys_rst) |-> busy && !(wrValid || busOe || memRdReq))
    else $error("outputs not idle after reset");
  wr_hold_a: assert property (wrValid && !wrReady |=> wrValid && $stable({wrIsData, wrByte}))
    else $error("offered byte changed before accept");
  rdreq_pulse_a: assert property (memRdReq |=> !memRdReq)
    else $error("fetch request longer than one cycle");
  busy_core_a: assert property (coreBusy |=> busy)
    else $error("busy does not follow core");
  en_write_a: assert property (enWr_s |-> ##[3:7] wrValid)
    else $error("enable write not taken");
  strobe_write_a: assert property (stWr_s |-> ##[3:7] wrValid)
    else $error("strobe write not taken");
  cs_write_a: assert property (csWr_s |-> ##[3:7] wrValid)
    else $error("select edge write not taken");
  data_read_a: assert property (dRd_s |-> ##[1:6] memRdReq)
    else $error("data read fetched nothing");
endmodule : ehp_host_port_sva

// >>> sim/ehp_host_model.sv
`timescale 1ns/100ps
//----------------------------
// host side model
//----------------------------
module ehp_host_model (
  input wire logic       ref_clk,
  input wire logic       busy,
  input wire logic       busOe,
  input wire logic [7:0] busOut,
  output logic           csN,
  output logic           rwWrN,
  output logic           enRdN,
  output logic           dcSel,
  output logic     [7:0] busIn
);
  logic [7:0] dq;
  logic       drv;
  // a released bus shows the inverse, never a friendly stale value
  assign busIn = busOe ? busOut : (drv ? dq : ~dq);
  initial begin
    {csN, rwWrN, enRdN, dcSel, drv} = 5'h1D;
    dq = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic acc(input logic [1:0] m, input bit f, input bit rd, input logic dc,
                     input logic [7:0] b, input bit nw, output logic [7:0] got);
    // a busy that never drops is left to the bench watchdog
    while (!nw && busy === 1'h1) begin
      tick(1);
    end
    tick(1);
    dcSel <= dc;
    dq <= b;
    drv <= !rd;
    if (m == 2'h3) begin
      rwWrN <= rd;
      csN <= 1'h0;
      tick(4);
      @(negedge ref_clk) got = busIn;
      tick(1);
      enRdN <= 1'h0;
    end else if (!f) begin
      csN <= 1'h0;
      tick(3);
      if (rd) enRdN <= 1'h0;
      else rwWrN <= 1'h0;
      tick(4);
      @(negedge ref_clk) got = busIn;
      tick(1);
      enRdN <= 1'h1;
      rwWrN <= 1'h1;
    end else begin
      if (rd) enRdN <= 1'h0;
      else rwWrN <= 1'h0;
      tick(3);
      csN <= 1'h0;
      tick(4);
      csN <= 1'h1;
    end
    tick(4);
    csN <= 1'h1;
    rwWrN <= 1'h1;
    enRdN <= 1'h1;
    drv <= 1'h1;
    tick(4);
  endtask : acc
  // link clock of 48 ns runs only inside a frame
  task automatic ser(input bit three, input logic dc, input logic [7:0] b, input int nb);
    logic [8:0] v;
    v = {dc, b};
    tick(1);
    dcSel <= three ? ~dc : dc;
    dq <= 8'h00;
    csN <= 1'h0;
    tick(1);
    #7;
    for (int i = 0; i < nb; i++) begin
      dq[1] = v[(three ? 8 : 7) - i];
      #24 dq[0] = 1'h1;
      #24 dq[0] = 1'h0;
    end
    tick(1);
    csN <= 1'h1;
    tick(6);
  endtask : ser
endmodule : ehp_host_model

// >>> sim/ehp_host_port_tb.sv
`timescale 1ns/100ps
//----------------------------
// host port bench
//----------------------------
module ehp_host_port_tb;
  logic        ref_clk, sys_rst, reset_n_pin, iface_sel_lo, iface_sel_hi;
  logic        csN, rwWrN, enRdN, dcSel, coreBusy, memRdValid, wrReady, hold;
  logic        busOe, memRdReq, wrValid, wrIsData, busy, overflow;
  logic [7:0]  busIn, busOut, statusByte, memRdData, wrByte, memLast, b, g, e;
  logic [1:0]  ifaceMode, m;
  logic [1:0]  mt [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  logic [31:0] seed, r, rc;
  logic [8:0]  expQ [$];
  int          error_cnt, n_tests;
  ehp_host_port i_dut (.serialClk(busIn[0]), .*);
  ehp_host_model i_host (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string n, input logic [8:0] ex, input logic [8:0] v);
    n_tests++;
    if (v !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, ex, v);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic drain();
    int k;
    k = 0;
    while (expQ.size() > 0 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    chk("left", 9'h000, 9'(expQ.size()));
  endtask : drain
  task automatic setMode(input logic [1:0] md);
    drain();
    iface_sel_hi <= md[1];
    iface_sel_lo <= md[0];
    reset_n_pin <= 1'h0;
    repeat (4) @(posedge ref_clk);
    reset_n_pin <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk("mode", {7'h00, md}, {7'h00, ifaceMode});
  endtask : setMode
  // core side: random accept stalls, fetched bytes remembered for reads
  always @(posedge ref_clk) begin
    rc = rnd();
    wrReady <= !hold && rc[1:0] != 2'h0;
    memRdValid <= memRdReq === 1'h1;
    if (memRdReq === 1'h1) begin
      memRdData <= rc[15:8];
      memLast <= rc[15:8];
    end
    if (!sys_rst && wrValid === 1'h1 && wrReady === 1'h1)
      chk("wr", expQ.size() > 0 ? expQ.pop_front() : 9'h1FF, {wrIsData, wrByte});
  end
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {sys_rst, reset_n_pin, iface_sel_hi, iface_sel_lo} = 4'hF;
    {coreBusy, hold} = 2'h0;
    statusByte = 8'h00;
    seed = 32'hF6F781EA;
    error_cnt = 0;
    n_tests = 0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'h0;
    for (int k = 0; k < 4; k++) begin
      m = mt[k];
      setMode(m);
      if (!m[0]) i_host.ser(m[1], 1'h1, 8'h5A, 5);
      for (int i = 0; i < 4; i++) begin
        r = rnd();
        b = r[7:0];
        expQ.push_back({i[0], b});
        if (m[0]) i_host.acc(m, i[1], 1'h0, i[0], b, 1'h0, g);
        else i_host.ser(m[1], i[0], b, m[1] ? 9 : 8);
      end
      r = rnd();
      statusByte <= r[7:0];
      i_host.acc(m, 1'h0, 1'h1, 1'h0, 8'h00, 1'h0, g);
      if (m[0]) begin
        chk("status", {1'h0, statusByte}, {1'h0, g});
        i_host.acc(m, 1'h0, 1'h1, 1'h1, 8'h00, 1'h0, g);
        e = memLast;
        i_host.acc(m, 1'h0, 1'h1, 1'h1, 8'h00, 1'h0, g);
        chk("rdata", {1'h0, e}, {1'h0, g});
      end else begin
        chk("serial read", 9'h0FF, {1'h0, g});
      end
      $display("mode %0d test done", m);
    end
    drain();
    chk("overflow", 9'h000, {8'h00, overflow});
    hold <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      if (i < 5) expQ.push_back({1'h1, r[7:0]});
      i_host.acc(2'h3, 1'h0, 1'h0, 1'h1, r[7:0], 1'h1, g);
    end
    chk("overflow", 9'h001, {8'h00, overflow});
    chk("busy", 9'h001, {8'h00, busy});
    hold <= 1'h0;
    coreBusy <= 1'h1;
    repeat (3) @(posedge ref_clk);
    coreBusy <= 1'h0;
    drain();
    $display("fifo test done");
    report_and_stop();
  end
endmodule : ehp_host_port_tb
bind ehp_host_port ehp_host_port_sva i_sva (.*);
